// file: lvdc_analog_model.sv
`timescale 1ns/1ps
`default_nettype none

module lvdc_analog_model (
    input  wire logic       detectorPower,
    input  wire logic       externalTripSelect,
    input  wire logic [3:0] dividerTap,
    input  wire logic [3:0] supplyLevel,
    input  wire logic       externalLow,
    output logic            comparatorLow
);
    // ************************************************
    // Comparator against the reference set point
    // ************************************************
    // Supply is given in tap steps: below the selected tap means low voltage
    // An unpowered comparator holds its output low, it never floats high
    assign comparatorLow = detectorPower && (externalTripSelect ? externalLow
                                                                : supplyLevel < dividerTap);
endmodule

`default_nettype wire

// file: lvdc_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module lvdc_monitor
    import lvdc_pkg::*;
#(
    parameter int SETTLE_CYCLES = LVDC_SETTLE_CYC
)(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    input  wire logic        sleeping,
    input  wire logic        comparatorLow,
    input  wire logic        detectorPower,
    input  wire logic        externalTripSelect,
    input  wire logic [3:0]  dividerTap,
    input  wire logic        wakeRequest,
    input  wire logic        vectorRequest
);
    // ************************************************
    // Data phase tracking of control accesses
    // ************************************************
    logic addrCtrl;
    logic rdCtrl;
    logic wrCtrl;

    assign addrCtrl = hsel && hready && htrans[1] && haddr == LVDC_CTRL_ADDR;

    always_ff @(posedge clock)
    begin
        rdCtrl <= rst_n && addrCtrl && !hwrite;
        wrCtrl <= rst_n && addrCtrl && hwrite;
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence lowHeld;
        (sleeping && detectorPower && comparatorLow) [*4];
    endsequence

    AST_RSVD_ZERO: assert property (rdCtrl |-> hrdata[7:6] == 2'b00)
        else $error("control bits 7-6 read nonzero");
    AST_POWER_FOLLOWS: assert property (wrCtrl |-> ##2 detectorPower == $past(hwdata[4], 2))
        else $error("detector power does not follow enable write");
    AST_EXT_ROUTE: assert property (wrCtrl |-> ##2
        externalTripSelect == ($past(hwdata[4:0], 2) == 5'h1f))
        else $error("external input routing wrong");
    AST_TAP_SELECT: assert property (wrCtrl |-> ##2
        dividerTap == (($past(hwdata[4], 2) && $past(hwdata[3:0], 2) != 4'hf) ? $past(hwdata[3:0], 2) : 4'h0))
        else $error("divider tap wrong");
    AST_RESET_OFF: assert property ($rose(rst_n) |-> !detectorPower && !wakeRequest && !vectorRequest)
        else $error("outputs active after reset");
    AST_WAKE_CAUSE: assert property (wakeRequest |-> detectorPower && $past(sleeping))
        else $error("wake without sleep or power");
    AST_WAKE_TRIP: assert property (lowHeld |-> wakeRequest)
        else $error("trip in sleep did not wake");
    AST_NO_WAKE: assert property (!sleeping |=> !wakeRequest)
        else $error("wake while awake");
    AST_VECTOR_POWERED: assert property (vectorRequest |-> detectorPower || $past(detectorPower))
        else $error("vector request with detector off");
endmodule

bind lvdc_top lvdc_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) i_lvdc_monitor (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .sleeping(sleeping), .comparatorLow(comparatorLow),
    .detectorPower(detectorPower), .externalTripSelect(externalTripSelect), .dividerTap(dividerTap),
    .wakeRequest(wakeRequest), .vectorRequest(vectorRequest)
);

`default_nettype wire

// file: lvdc_pkg.sv
package lvdc_pkg;

    // ************************************************
    // Register map
    // ************************************************
    localparam logic [11:0] LVDC_CTRL_ADDR    = 12'h000;
    localparam logic [11:0] LVDC_STATUS_ADDR  = 12'h004;
    localparam logic [11:0] LVDC_IRQCTL_ADDR  = 12'h008;

    // ************************************************
    // Control register fields
    // ************************************************
    localparam int          LVDC_STABLE_BIT   = 5;
    localparam int          LVDC_POWER_BIT    = 4;
    localparam int          LVDC_TRIP_LSB     = 0;
    localparam int          LVDC_TRIP_W       = 4;
    localparam logic [3:0]  LVDC_TRIP_RESET   = 4'h5;
    localparam logic [3:0]  LVDC_TRIP_EXT     = 4'hf;
    localparam logic [3:0]  LVDC_TRIP_RSVD    = 4'h0;

    // ************************************************
    // Status and interrupt-control fields
    // ************************************************
    localparam int          LVDC_FLAG_BIT     = 0;
    localparam int          LVDC_IE_BIT       = 0;
    localparam int          LVDC_GIE_BIT      = 1;

    // ************************************************
    // Timing
    // ************************************************
    localparam int          LVDC_CLK_MHZ      = 25;
    localparam int          LVDC_SETTLE_US    = 50;
    localparam int          LVDC_SETTLE_CYC   = LVDC_SETTLE_US * LVDC_CLK_MHZ;

    typedef enum logic [2:0] {
        LVDC_OFF    = 3'b001,
        LVDC_SETTLE = 3'b010,
        LVDC_READY  = 3'b100
    } lvdc_state_t;

endpackage

// file: lvdc_ref_if.sv
`timescale 1ns/1ps
`default_nettype none

// Carries the reference power request and stable answer between the two modules
interface lvdc_ref_if;
    logic request;
    logic stable;

    modport owner  (output request, input stable);
    modport timer  (input request, output stable);
endinterface

`default_nettype wire

// file: lvdc_ref_timer.sv
`timescale 1ns/1ps
`default_nettype none

module lvdc_ref_timer
    import lvdc_pkg::*;
#(
    parameter int SETTLE_CYCLES = LVDC_SETTLE_CYC
)(
    input  wire logic    clock,
    input  wire logic    rst_n,
    input  wire logic    otherUserOn,
    lvdc_ref_if.timer    refBus
);

    // The settle counter is sixteen bits wide and has to count at least once
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535)
    begin : gSettleRange
        $error("SETTLE_CYCLES out of range");
    end

    logic        refRunning;
    logic [15:0] settleCount;

    // Fixed delay in clock cycles; stays valid only at the nominal clock rate
    always_ff @(posedge clock)
    begin
        if (!rst_n || !refBus.request)
        begin
            settleCount    <= 16'h0000;
            refBus.stable  <= 1'b0;
        end
        else if (refRunning)
            refBus.stable  <= 1'b1;
        else if (settleCount == 16'(SETTLE_CYCLES - 1))
            refBus.stable  <= 1'b1;
        else
            settleCount    <= settleCount + 16'h0001;
    end

    // A reference already held up by the brown-out circuit needs no start-up delay
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            refRunning <= 1'b0;
        else
            refRunning <= otherUserOn | (refBus.request & refBus.stable);
    end

endmodule

`default_nettype wire

// file: lvdc_top.sv
`timescale 1ns/1ps
`default_nettype none

module lvdc_top
    import lvdc_pkg::*;
#(
    parameter int SETTLE_CYCLES = LVDC_SETTLE_CYC
)(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        comparatorLow,
    input  wire logic        brownoutResetOn,
    input  wire logic        sleeping,
    output logic             detectorPower,
    output logic             externalTripSelect,
    output logic      [3:0]  dividerTap,
    output logic             wakeRequest,
    output logic             vectorRequest
);

    // ************************************************
    // Elaboration checks
    // ************************************************
    // The settle counter is sixteen bits wide and has to count at least once
    if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535)
    begin : gSettleRange
        $error("SETTLE_CYCLES out of range");
    end

    // Trip field, power bit and stable bit must sit apart and below bits 7-6
    if (LVDC_TRIP_LSB + LVDC_TRIP_W > LVDC_POWER_BIT || LVDC_POWER_BIT >= LVDC_STABLE_BIT || LVDC_STABLE_BIT > 5)
    begin : gFieldLayout
        $error("control register fields overlap");
    end

    // The external input code must be the all-ones trip code
    if (LVDC_TRIP_EXT != 4'hf || LVDC_TRIP_W != 4)
    begin : gTripCodes
        $error("trip code constants inconsistent");
    end

    // ************************************************
    // Pin synchronisers
    // ************************************************
    // Both pins are asynchronous; only the second stage feeds any logic
    logic compMeta;
    logic compSync;
    logic borMeta;
    logic borSync;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            compMeta <= 1'b0;
            compSync <= 1'b0;
            borMeta  <= 1'b0;
            borSync  <= 1'b0;
        end
        else
        begin
            compMeta <= comparatorLow;
            compSync <= compMeta;
            borMeta  <= brownoutResetOn;
            borSync  <= borMeta;
        end
    end

    // ************************************************
    // AHB-Lite slave
    // ************************************************
    logic        wrPending;
    logic [11:0] wrAddr;
    logic        rdAccess;
    logic        wrCtrl;
    logic        wrStatus;
    logic        wrIrq;

    assign rdAccess = hsel & hready & htrans[1] & !hwrite;
    assign wrCtrl   = wrPending & (wrAddr == LVDC_CTRL_ADDR);
    assign wrStatus = wrPending & (wrAddr == LVDC_STATUS_ADDR);
    assign wrIrq    = wrPending & (wrAddr == LVDC_IRQCTL_ADDR);

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wrPending <= 1'b0;
            wrAddr    <= 12'h000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready)
            begin
                // A write commits one edge later, in its data phase, once hwdata is on the bus
                wrPending <= hsel & htrans[1] & hwrite;
                // Byte-lane bits play no part: every register is one aligned word
                wrAddr    <= {haddr[11:2], 2'b00};
            end
            else
                wrPending <= 1'b0;
        end
    end

    // ************************************************
    // Control register
    // ************************************************
    logic [3:0] tripSelect;
    logic       powerEnable;
    logic       irqEnable;
    logic       globalIrqEnable;
    logic       lowVoltageFlag;
    logic       refStable;

    lvdc_ref_if refBus ();

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            tripSelect  <= LVDC_TRIP_RESET;
            powerEnable <= 1'b0;
        end
        else if (wrCtrl)
        begin
            // Bits 7-6 and the stable bit have no storage, so writes to them vanish
            tripSelect  <= hwdata[LVDC_TRIP_LSB +: LVDC_TRIP_W];
            powerEnable <= hwdata[LVDC_POWER_BIT];
        end
    end

    // ************************************************
    // Interrupt enables
    // ************************************************
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            irqEnable       <= 1'b0;
            globalIrqEnable <= 1'b0;
        end
        else if (wrIrq)
        begin
            irqEnable       <= hwdata[LVDC_IE_BIT];
            globalIrqEnable <= hwdata[LVDC_GIE_BIT];
        end
    end

    // ************************************************
    // Reference timer
    // ************************************************
    // The brown-out circuit shares the reference, so its being on skips the settle wait
    assign refBus.request = powerEnable;
    assign refStable      = refBus.stable;

    lvdc_ref_timer #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) refTimer (
        .clock         (clock),
        .rst_n         (rst_n),
        .otherUserOn   (borSync),
        .refBus        (refBus)
    );

    // ************************************************
    // Detector state
    // ************************************************
    lvdc_state_t state;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            state <= LVDC_OFF;
        else
        begin
            case (state)
                LVDC_OFF:
                    if (powerEnable)
                        state <= LVDC_SETTLE;
                // Power-off leaves settling too, so a short enable never reaches READY
                LVDC_SETTLE:
                    if (!powerEnable)
                        state <= LVDC_OFF;
                    else if (refStable)
                        state <= LVDC_READY;
                LVDC_READY:
                    if (!powerEnable)
                        state <= LVDC_OFF;
                default:
                    state <= LVDC_OFF;
            endcase
        end
    end

    // ************************************************
    // Low-voltage flag
    // ************************************************
    logic tripEvent;

    // Comparator output is honoured while powered; before stability it may set falsely
    assign tripEvent = powerEnable & compSync;

    // Set beats a clear written in the same cycle so no trip is lost
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            lowVoltageFlag <= 1'b0;
        else if (tripEvent)
            lowVoltageFlag <= 1'b1;
        else if (wrStatus && hwdata[LVDC_FLAG_BIT])
            lowVoltageFlag <= 1'b0;
    end

    // ************************************************
    // Analog controls and wake
    // ************************************************
    logic validTrip;

    // Only a stable reference makes the flag a valid indication
    assign validTrip = lowVoltageFlag & (state == LVDC_READY) & irqEnable;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            detectorPower      <= 1'b0;
            externalTripSelect <= 1'b0;
            dividerTap         <= 4'h0;
        end
        else
        begin
            detectorPower      <= powerEnable;
            externalTripSelect <= powerEnable & (tripSelect == LVDC_TRIP_EXT);
            // Reserved code zero simply leaves the divider disconnected
            dividerTap         <= (powerEnable && tripSelect != LVDC_TRIP_EXT) ? tripSelect : 4'h0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            wakeRequest   <= 1'b0;
            vectorRequest <= 1'b0;
        end
        else
        begin
            wakeRequest   <= sleeping & powerEnable & tripEvent;
            // A level, standing until software clears the flag, disables the detector or clears either interrupt enable
            vectorRequest <= validTrip & globalIrqEnable;
        end
    end

    // ************************************************
    // Read-after-write forwarding
    // ************************************************
    logic [3:0] shownTrip;
    logic       shownPower;
    logic       shownIrqEnable;
    logic       shownGlobalIrq;
    logic       shownFlag;

    // A read issued in the data phase of a write must already see the new value
    assign shownTrip      = wrCtrl ? hwdata[LVDC_TRIP_LSB +: LVDC_TRIP_W] : tripSelect;
    assign shownPower     = wrCtrl ? hwdata[LVDC_POWER_BIT] : powerEnable;
    assign shownIrqEnable = wrIrq ? hwdata[LVDC_IE_BIT] : irqEnable;
    assign shownGlobalIrq = wrIrq ? hwdata[LVDC_GIE_BIT] : globalIrqEnable;
    // Mirrors the flag update, where a trip beats a clear in the same cycle
    assign shownFlag      = tripEvent | (lowVoltageFlag & !(wrStatus & hwdata[LVDC_FLAG_BIT]));

    // ************************************************
    // Read data
    // ************************************************
    logic [31:0] readWord;

    always_comb
    begin
        readWord = 32'h0000_0000;
        case ({haddr[11:2], 2'b00})
            LVDC_CTRL_ADDR:
            begin
                readWord[LVDC_STABLE_BIT]              = refStable;
                readWord[LVDC_POWER_BIT]               = shownPower;
                readWord[LVDC_TRIP_LSB +: LVDC_TRIP_W] = shownTrip;
                readWord[7:6]                          = 2'b00;
            end
            LVDC_STATUS_ADDR:
                readWord[LVDC_FLAG_BIT] = shownFlag;
            LVDC_IRQCTL_ADDR:
            begin
                readWord[LVDC_IE_BIT]  = shownIrqEnable;
                readWord[LVDC_GIE_BIT] = shownGlobalIrq;
            end
            default:
                readWord = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            hrdata <= 32'h0000_0000;
        else if (rdAccess)
            // Launched at the address phase, so the word stands through the data phase
            hrdata <= readWord;
    end

endmodule

`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import lvdc_pkg::*;
    localparam int SETTLE = 8;
    localparam logic [11:0] CTL = LVDC_CTRL_ADDR;
    localparam logic [11:0] STA = LVDC_STATUS_ADDR;
    typedef struct packed {logic [7:0] wd; logic [7:0] rd; logic [3:0] tap; logic ext;} lvdc_row_t;

    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        sleeping = 1'b0;
    logic        brownoutResetOn = 1'b0;
    logic [3:0]  supplyLevel = 4'hf;
    logic        comparatorLow;
    logic        detectorPower;
    logic        externalTripSelect;
    logic [3:0]  dividerTap;
    logic        wakeRequest;
    logic        vectorRequest;
    int          err_count = 0;
    int          samples_checked = 0;
    int          cycles = 0;
    lvdc_row_t   rows [17];

    lvdc_top #(.SETTLE_CYCLES(SETTLE)) i_lvdc_top (
        .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .comparatorLow(comparatorLow), .brownoutResetOn(brownoutResetOn), .sleeping(sleeping),
        .detectorPower(detectorPower), .externalTripSelect(externalTripSelect), .dividerTap(dividerTap),
        .wakeRequest(wakeRequest), .vectorRequest(vectorRequest)
    );

    lvdc_analog_model i_lvdc_analog_model (
        .detectorPower(detectorPower), .externalTripSelect(externalTripSelect), .dividerTap(dividerTap),
        .supplyLevel(supplyLevel), .externalLow(1'b1), .comparatorLow(comparatorLow)
    );

    always #20 clock = ~clock;

    // ************************************************
    // Bus master and comparisons
    // ************************************************
    task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clock);
        while (hreadyout !== 1'b1) @(posedge clock);
        q = hrdata;
    endtask

    task automatic chkReg(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chkPin(input string n, input logic [3:0] e, input logic [3:0] g);
        chkReg(n, {28'h0, e}, {28'h0, g});
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b1, d, q);
    endtask

    task automatic rdChk(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        chkReg(n, e, q & m);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Bounds a hang; the whole run needs well under a thousand cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            tally_and_finish();
        end
    end

    initial
    begin
        for (int k = 0; k < 16; k++)
            rows[k] = '{8'hf0 | k[7:0], 8'h10 | k[7:0], (k == 15) ? 4'h0 : k[3:0], k == 15};
        rows[16] = '{8'hcf, 8'h0f, 4'h0, 1'b0};
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        rdChk("ctrl", CTL, 32'hffffffff, 32'h05);
        wr(12'h00c, 32'hffffffff);
        rdChk("unmapped", 12'h00c, 32'hffffffff, 32'h0);
        $display("test reset done");
        foreach (rows[i])
        begin
            wr(CTL, {24'h0, rows[i].wd});
            repeat (2) @(posedge clock);
            chkPin("tap", rows[i].tap, dividerTap);
            chkPin("ext", {3'b000, rows[i].ext}, {3'b000, externalTripSelect});
            chkPin("power", {3'b000, rows[i].wd[4]}, {3'b000, detectorPower});
            rdChk("ctrl", CTL, 32'hdf, {24'h0, rows[i].rd});
        end
        $display("test table done");
        // Low supply during settling may set the flag falsely
        supplyLevel <= 4'h0;
        wr(CTL, 32'h15);
        rdChk("stable", CTL, 32'h20, 32'h0);
        repeat (SETTLE + 4) @(posedge clock);
        rdChk("stable", CTL, 32'h20, 32'h20);
        chkPin("vector", 4'h0, {3'b000, vectorRequest});
        wr(STA, 32'h1);
        rdChk("flag", STA, 32'h1, 32'h1);
        supplyLevel <= 4'hf;
        repeat (4) @(posedge clock);
        wr(STA, 32'h1);
        rdChk("flag", STA, 32'h1, 32'h0);
        wr(LVDC_IRQCTL_ADDR, 32'h3);
        supplyLevel <= 4'h0;
        sleeping <= 1'b1;
        repeat (5) @(posedge clock);
        chkPin("wake", 4'h1, {3'b000, wakeRequest});
        chkPin("vector", 4'h1, {3'b000, vectorRequest});
        rdChk("flag", STA, 32'h1, 32'h1);
        sleeping <= 1'b0;
        supplyLevel <= 4'hf;
        repeat (4) @(posedge clock);
        chkPin("wake", 4'h0, {3'b000, wakeRequest});
        wr(STA, 32'h1);
        repeat (2) @(posedge clock);
        chkPin("vector", 4'h0, {3'b000, vectorRequest});
        $display("test flag done");
        wr(CTL, 32'h05);
        supplyLevel <= 4'h0;
        repeat (5) @(posedge clock);
        chkPin("power", 4'h0, {3'b000, detectorPower});
        rdChk("stable", CTL, 32'h20, 32'h0);
        rdChk("flag", STA, 32'h1, 32'h0);
        brownoutResetOn <= 1'b1;
        wr(CTL, 32'h15);
        repeat (3) @(posedge clock);
        rdChk("stable", CTL, 32'h20, 32'h20);
        $display("test shared reference done");
        rst_n <= 1'b0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chkPin("power", 4'h0, {3'b000, detectorPower});
        chkPin("ready", 4'h1, {3'b000, hreadyout});
        chkPin("resp", 4'h0, {3'b000, hresp});
        rdChk("ctrl", CTL, 32'hffffffff, 32'h05);
        rdChk("irq", LVDC_IRQCTL_ADDR, 32'hffffffff, 32'h0);
        wr(CTL, 32'h000000e5);
        rdChk("ro bits", CTL, 32'hffffffff, 32'h05);
        $display("test mid reset done");
        tally_and_finish();
    end
endmodule

`default_nettype wire
